// ---- src/acr_pkg.sv ----
/*
 * Constants of the acquisition configuration register set: register
 * addresses, field positions, power-up values and decoded encodings.
 * Assumes one synchronous write/read port fed by the serial front end.
 */
package acr_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 28;
    localparam int MODE_W = 4;
    localparam int GEN_W  = 28;
    localparam int CHA_W  = 17;

    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_CHA  = 4'h1;
    localparam logic [3:0] ADDR_GEN  = 4'h3;

    localparam logic [3:0]  MODE_RST = 4'h0;
    localparam logic [27:0] GEN_RST  = 28'h1c00004;
    localparam logic [16:0] CHA_RST  = 17'h003c0;

    // General register fields
    localparam int GEN_SEQ_LSB  = 24;
    localparam int GEN_DCHP_BIT = 23;
    localparam int GEN_CHP_BIT  = 22;
    localparam int GEN_SW_LSB   = 16;
    localparam int GEN_SRC_LSB  = 11;
    localparam int GEN_VSW_LSB  = 7;
    localparam int GEN_PD_LSB   = 0;

    // Channel A fields
    localparam int CHA_CAL_LSB  = 14;
    localparam int CHA_PATH_LSB = 9;
    localparam int CHA_GAIN_LSB = 7;
    localparam int CHA_OSF_BIT  = 6;
    localparam int CHA_OSR_BIT  = 5;
    localparam int CHA_CR_BIT   = 4;
    localparam int CHA_AVG_LSB  = 0;

    localparam logic [10:0] CAL_FIXED_VALUE = 11'h60c;
    localparam logic [2:0]  CAL_LAST_STORED = 3'h5;
    localparam logic [3:0]  AVG_LAST_VALID  = 4'ha;
    localparam logic [3:0]  AVG_RAW         = 4'hf;
    localparam logic [4:0]  SEQ_LEN_ZERO    = 5'h10;
    localparam logic [7:0]  OSR_LOW         = 8'h40;
    localparam logic [7:0]  OSR_HIGH        = 8'h80;
    localparam logic [3:0]  CR_LOW          = 4'h4;
    localparam logic [3:0]  CR_HIGH         = 4'h8;
    localparam logic [3:0]  CR_UNCHOPPED    = 4'h1;
    localparam logic [6:0]  GAIN_6          = 7'h06;
    localparam logic [6:0]  GAIN_24         = 7'h18;
    localparam logic [6:0]  GAIN_50         = 7'h32;
    localparam logic [6:0]  GAIN_100        = 7'h64;

    typedef enum logic [3:0] {
        MODE_FUSE_LOAD, MODE_SINGLE, MODE_ALT_DUAL, MODE_WAKE_UP,
        MODE_ALARM, MODE_FUSE_PROG, MODE_POWER_DOWN, MODE_INT_SINGLE,
        MODE_TEST_RSVD
    } acr_mode_t;

endpackage : acr_pkg

// ---- src/acr_config_regs.sv ----
/*
 * Configuration register set: mode, general and channel A registers,
 * their decoding, and the A/B sequence for alternating dual mode.
 * Assumes the serial front end and conversion engine share clk.
 */
`timescale 1ns/1ps
module acr_config_regs
    import acr_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Register port from the serial front end
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [DATA_W-1:0] wrData,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic      [DATA_W-1:0] rdData,
    // Conversion engine handshake
    input  wire logic              convBusy,
    input  wire logic              measStart,
    input  wire logic              measDone,
    // Decoded mode and sequence
    output acr_mode_t              opMode,
    output logic                   chanB,
    output logic      [4:0]        seqLen,
    output logic                   dechopEn,
    output logic                   chopEn,
    // Analog controls
    output logic      [7:0]        srcCurrentUa,
    output logic      [5:0]        inputSwitch,
    output logic      [3:0]        voltSwitch,
    output logic      [6:0]        powerDown,
    // Channel A measurement set-up
    output logic      [2:0]        voltCalIdx,
    output logic                   calFixed,
    output logic      [4:0]        pathSwitch,
    output logic      [6:0]        gainValue,
    output logic                   osfHigh,
    output logic      [7:0]        osrRatio,
    output logic      [3:0]        chopRatio,
    output logic      [3:0]        avgLog2,
    output logic                   avgReserved,
    output logic                   rawMode
);

    function automatic acr_mode_t decodeMode(input logic [3:0] code);
        acr_mode_t m;
        m = MODE_TEST_RSVD;
        if (!code[3]) begin
            m = acr_mode_t'(code);
        end
        return m;
    endfunction : decodeMode

    function automatic logic [6:0] decodeGain(input logic [1:0] code);
        logic [6:0] g;
        g = GAIN_6;
        unique case (code)
            2'b00: g = GAIN_6;
            2'b01: g = GAIN_24;
            2'b10: g = GAIN_50;
            2'b11: g = GAIN_100;
        endcase
        return g;
    endfunction : decodeGain

    // Shadow registers written by the host, active copies used
    logic [MODE_W-1:0] modeReg_r;
    logic [GEN_W-1:0]  genReg_r;
    logic [CHA_W-1:0]  chaReg_r;
    logic [GEN_W-1:0]  actGen_r;
    logic [CHA_W-1:0]  actCha_r;
    logic [3:0]        seqCount_r;

    wire wrMode = wrEn && (wrAddr == ADDR_MODE);
    wire wrGen  = wrEn && (wrAddr == ADDR_GEN);
    wire wrCha  = wrEn && (wrAddr == ADDR_CHA);

    // Mid-conversion the active set is frozen; idle it tracks shadows
    wire loadActive = measStart || !convBusy;

    wire acr_mode_t modeDec = decodeMode(modeReg_r);
    wire isDual = (modeDec == MODE_ALT_DUAL);

    wire [3:0] seqCode = actGen_r[GEN_SEQ_LSB +: 4];
    wire [4:0] seqLenDec = (seqCode == 4'h0) ? SEQ_LEN_ZERO
                                             : {1'b0, seqCode};
    wire [3:0] seqLast = 4'(seqLenDec - 5'h01);
    wire       seqWrap = (seqCount_r == seqLast);

    wire       dechopA = actGen_r[GEN_DCHP_BIT];
    wire       chopA   = actGen_r[GEN_CHP_BIT];
    wire [4:0] srcCode = actGen_r[GEN_SRC_LSB +: 5];
    wire [2:0] calSel  = actCha_r[CHA_CAL_LSB +: 3];
    wire [1:0] gainSel = actCha_r[CHA_GAIN_LSB +: 2];
    wire [3:0] avgSel  = actCha_r[CHA_AVG_LSB +: 4];
    wire       crSel   = actCha_r[CHA_CR_BIT];

    wire [3:0] chopRatioDec = (!chopA && !dechopA) ? CR_UNCHOPPED
                            : (crSel ? CR_HIGH : CR_LOW);

    wire [DATA_W-1:0] rdMux =
        (rdAddr == ADDR_MODE) ? DATA_W'(modeReg_r) :
        (rdAddr == ADDR_CHA)  ? DATA_W'(chaReg_r)  :
        (rdAddr == ADDR_GEN)  ? DATA_W'(genReg_r)  : '0;

    // Host writes accepted in every mode, no busy lockout
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            modeReg_r <= MODE_RST;
            genReg_r  <= GEN_RST;
            chaReg_r  <= CHA_RST;
        end else begin
            if (wrMode) modeReg_r <= wrData[MODE_W-1:0];
            if (wrGen)  genReg_r  <= wrData[GEN_W-1:0];
            if (wrCha)  chaReg_r  <= wrData[CHA_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            actGen_r <= GEN_RST;
            actCha_r <= CHA_RST;
        end else if (loadActive) begin
            actGen_r <= genReg_r;
            actCha_r <= chaReg_r;
        end
    end

    // A/B alternation counts only in dual mode
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seqCount_r <= 4'h0;
            chanB      <= 1'b0;
        end else if (!isDual) begin
            seqCount_r <= 4'h0;
            chanB      <= 1'b0;
        end else if (measDone) begin
            seqCount_r <= seqWrap ? 4'h0 : 4'(seqCount_r + 4'h1);
            if (seqWrap) chanB <= !chanB;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdData <= '0;
            opMode <= MODE_FUSE_LOAD;
        end else begin
            rdData <= rdMux;
            opMode <= modeDec;
        end
    end

    // Decoded general controls
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seqLen       <= 5'h01;
            dechopEn     <= 1'b1;
            chopEn       <= 1'b1;
            srcCurrentUa <= 8'h00;
            inputSwitch  <= 6'h00;
            voltSwitch   <= 4'h0;
            powerDown    <= GEN_RST[6:0];
        end else begin
            seqLen       <= seqLenDec;
            dechopEn     <= dechopA;
            chopEn       <= chopA;
            srcCurrentUa <= {srcCode, 3'b000};
            inputSwitch  <= actGen_r[GEN_SW_LSB +: 6];
            voltSwitch   <= actGen_r[GEN_VSW_LSB +: 4];
            powerDown    <= actGen_r[GEN_PD_LSB +: 7];
        end
    end

    // Decoded channel A set-up
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            voltCalIdx  <= 3'h0;
            calFixed    <= 1'b0;
            pathSwitch  <= 5'h01;
            gainValue   <= GAIN_100;
            osfHigh     <= 1'b1;
            osrRatio    <= OSR_LOW;
            chopRatio   <= CR_LOW;
            avgLog2     <= 4'h0;
            avgReserved <= 1'b0;
            rawMode     <= 1'b0;
        end else begin
            voltCalIdx  <= calSel;
            calFixed    <= (calSel > CAL_LAST_STORED);
            pathSwitch  <= actCha_r[CHA_PATH_LSB +: 5];
            gainValue   <= decodeGain(gainSel);
            osfHigh     <= actCha_r[CHA_OSF_BIT];
            osrRatio    <= actCha_r[CHA_OSR_BIT] ? OSR_HIGH
                                                 : OSR_LOW;
            chopRatio   <= chopRatioDec;
            avgLog2     <= (avgSel > AVG_LAST_VALID) ? 4'h0 : avgSel;
            avgReserved <= (avgSel > AVG_LAST_VALID) && (avgSel != AVG_RAW);
            rawMode     <= (avgSel == AVG_RAW);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_MODE_WRITE: assert property (
        wrMode |=> modeReg_r == $past(wrData[MODE_W-1:0]))
        else $error("Mode write not stored");
    AST_MODE_DECODE: assert property (
        modeReg_r[3] |=> opMode == MODE_TEST_RSVD)
        else $error("Test code not decoded as reserved");
    AST_SEQ_IGNORED: assert property (
        !isDual |=> !chanB && seqCount_r == 4'h0)
        else $error("Sequence active outside dual mode");
    AST_SEQ_BOUND: assert property (
        isDual && measDone && seqWrap && $stable(actGen_r)
        |=> chanB != $past(chanB))
        else $error("Channel not switched at sequence end");
    AST_FROZEN: assert property (
        convBusy && !measStart |=> $stable(actGen_r) && $stable(actCha_r))
        else $error("Active set changed mid conversion");
    AST_CURRENT: assert property (
        ##1 srcCurrentUa == 8'($past(srcCode) * 8))
        else $error("Source current not code times eight");
    AST_GAIN_LOW: assert property (
        gainSel == 2'b01 |=> gainValue == GAIN_24)
        else $error("Gain code one not 24");
    AST_CAL_FIXED: assert property (
        calSel >= 3'h6 |=> calFixed)
        else $error("Fixed calibration not chosen");
    AST_UNCHOPPED: assert property (
        !chopA && !dechopA |=> chopRatio == CR_UNCHOPPED)
        else $error("Unchopped ratio not one");
    AST_RAW: assert property (
        avgSel == AVG_RAW |=> rawMode && !avgReserved)
        else $error("Raw code not decoded");
    AST_OSR: assert property (
        actCha_r[CHA_OSR_BIT] |=> osrRatio == OSR_HIGH)
        else $error("Oversample ratio not 128");

    // Register port: stores and registered read-back
    AST_GEN_WRITE: assert property (
        wrGen |=> genReg_r == $past(wrData[GEN_W-1:0]))
        else $error("General write not stored");
    AST_CHA_WRITE: assert property (
        wrCha |=> chaReg_r == $past(wrData[CHA_W-1:0]))
        else $error("Channel A write not stored");
    AST_READ_MODE: assert property (
        rdAddr == ADDR_MODE |=> rdData == DATA_W'($past(modeReg_r)))
        else $error("Mode read back wrong");
    AST_READ_CHA: assert property (
        rdAddr == ADDR_CHA |=> rdData == DATA_W'($past(chaReg_r)))
        else $error("Channel A read back wrong");
    AST_READ_GEN: assert property (
        rdAddr == ADDR_GEN |=> rdData == $past(genReg_r))
        else $error("General read back wrong");

    // Active copy follows shadows only at safe points
    AST_LOAD_START: assert property (
        measStart |=> actGen_r == $past(genReg_r)
                      && actCha_r == $past(chaReg_r))
        else $error("Active set not loaded at start");
    AST_TRACK_IDLE: assert property (
        !convBusy |=> actGen_r == $past(genReg_r)
                      && actCha_r == $past(chaReg_r))
        else $error("Active set not tracking when idle");

    // General register decode
    AST_SEQ_ZERO: assert property (
        seqCode == 4'h0 |=> seqLen == SEQ_LEN_ZERO)
        else $error("Sequence code zero not sixteen");
    AST_SEQ_CODE: assert property (
        seqCode != 4'h0 |=> seqLen == {1'b0, $past(seqCode)})
        else $error("Sequence length not code value");
    AST_DUAL_HOLD: assert property (
        isDual && !measDone |=> $stable(chanB))
        else $error("Channel changed without measurement");
    AST_DUAL_COUNT: assert property (
        isDual && measDone && !seqWrap
        |=> seqCount_r == $past(seqCount_r) + 4'h1)
        else $error("Sequence count not advanced");
    AST_CHOP_BITS: assert property (
        ##1 dechopEn == $past(dechopA) && chopEn == $past(chopA))
        else $error("Chop enables not from general register");
    AST_IN_SWITCH: assert property (
        ##1 inputSwitch == $past(actGen_r[GEN_SW_LSB +: 6]))
        else $error("Input switches not positive logic");
    AST_VOLT_SWITCH: assert property (
        ##1 voltSwitch == $past(actGen_r[GEN_VSW_LSB +: 4]))
        else $error("Voltage switches not from register");
    AST_POWER_DOWN: assert property (
        ##1 powerDown == $past(actGen_r[GEN_PD_LSB +: 7]))
        else $error("Power-down bits not from register");

    // Channel A and mode decode
    AST_CAL_STORED: assert property (
        calSel <= CAL_LAST_STORED
        |=> !calFixed && voltCalIdx == $past(calSel))
        else $error("Stored calibration not chosen");
    AST_PATH: assert property (
        ##1 pathSwitch == $past(actCha_r[CHA_PATH_LSB +: 5]))
        else $error("Path switches not from register");
    AST_GAIN_SIX: assert property (
        gainSel == 2'b00 |=> gainValue == GAIN_6)
        else $error("Gain code zero not 6");
    AST_GAIN_FIFTY: assert property (
        gainSel == 2'b10 |=> gainValue == GAIN_50)
        else $error("Gain code two not 50");
    AST_GAIN_HUNDRED: assert property (
        gainSel == 2'b11 |=> gainValue == GAIN_100)
        else $error("Gain code three not 100");
    AST_OSF: assert property (
        ##1 osfHigh == $past(actCha_r[CHA_OSF_BIT]))
        else $error("Oversample frequency bit not passed");
    AST_OSR_LOW: assert property (
        !actCha_r[CHA_OSR_BIT] |=> osrRatio == OSR_LOW)
        else $error("Oversample ratio not 64");
    AST_CHOP_RATIO: assert property (
        chopA || dechopA
        |=> chopRatio == ($past(crSel) ? CR_HIGH : CR_LOW))
        else $error("Chopping ratio not 4 or 8");
    AST_AVG_VALID: assert property (
        avgSel <= AVG_LAST_VALID
        |=> avgLog2 == $past(avgSel) && !avgReserved && !rawMode)
        else $error("Valid averaging code misdecoded");
    AST_AVG_RSVD: assert property (
        avgSel > AVG_LAST_VALID && avgSel != AVG_RAW
        |=> avgReserved && !rawMode && avgLog2 == 4'h0)
        else $error("Reserved averaging code misdecoded");
    AST_MODE_VALID: assert property (
        !modeReg_r[3] |=> opMode == acr_mode_t'($past(modeReg_r)))
        else $error("Valid mode code misdecoded");

    COV_DUAL_SWITCH: cover property (isDual && measDone && seqWrap);
    COV_WRITE_BUSY: cover property (convBusy && wrGen);
    COV_TEST_MODE: cover property (wrMode && wrData[3]);
    COV_UNCHOPPED: cover property (!chopA && !dechopA);
    COV_RAW: cover property (avgSel == AVG_RAW);

endmodule : acr_config_regs

// ---- sim/acr_host_model.sv ----
/*
 * Host side of the configuration register port: word writes and reads.
 * Assumes the bench calls its tasks and that clk is shared with the block.
 */
`timescale 1ns/1ps
module acr_host_model
    import acr_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Register port
    output logic                   wrEn,
    output logic      [ADDR_W-1:0] wrAddr,
    output logic      [DATA_W-1:0] wrData,
    output logic      [ADDR_W-1:0] rdAddr,
    input  wire logic [DATA_W-1:0] rdData
);
    initial begin
        wrEn   = 1'b0;
        wrAddr = 4'h0;
        wrData = 28'h0;
        rdAddr = 4'h0;
    end

    task automatic wr(input logic [3:0] a, input logic [27:0] v);
        @(negedge clk);
        wrEn   = 1'b1;
        wrAddr = a;
        wrData = v;
        @(negedge clk);
        wrEn   = 1'b0;
        // Stale data must never pass for a new write
        wrData = ~v;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [27:0] v);
        @(negedge clk);
        rdAddr = a;
        @(negedge clk);
        v = rdData;
    endtask : rd
endmodule : acr_host_model

// ---- sim/tb.sv ----
/*
 * Self-checking bench of the configuration register set.
 * Assumes the host model drives the register port; the bench drives
 * the conversion handshake at the falling edge.
 */
`timescale 1ns/1ps
module tb;
    import acr_pkg::*;
    typedef struct packed {
        logic [27:0] gen;
        logic [16:0] cha;
        logic [31:0] eg;
        logic [34:0] ec;
    } acr_row_t;

    logic        clk, rstn, convBusy, measStart, measDone, wrEn, chanB;
    logic        dechopEn, chopEn, calFixed, osfHigh, avgReserved, rawMode;
    logic [3:0]  wrAddr, rdAddr, voltSwitch, chopRatio, avgLog2;
    logic [27:0] wrData, rdData, d;
    logic [4:0]  seqLen, pathSwitch;
    logic [7:0]  srcCurrentUa, osrRatio;
    logic [5:0]  inputSwitch;
    logic [6:0]  powerDown, gainValue;
    logic [2:0]  voltCalIdx;
    acr_mode_t   opMode;
    int          badCount = 0;
    int          numChecks = 0;
    wire logic [31:0] genV = {seqLen, dechopEn, chopEn, srcCurrentUa,
                              inputSwitch, voltSwitch, powerDown};
    wire logic [34:0] chaV = {voltCalIdx, calFixed, pathSwitch, gainValue,
        osfHigh, osrRatio, chopRatio, avgLog2, avgReserved, rawMode};
    // Path patterns are the allowed ones; current path has aux switches
    // open
    acr_row_t rows [4] = '{
        '{28'h1c0f804, 17'h1423a, {5'd1, 2'b11, 8'd248, 17'h00004},
          {3'd5, 1'b0, 5'h01, 7'd6, 1'b0, 8'd128, 4'd8, 4'd10, 2'b00}},
        '{28'h0000800, 17'h190cb, {5'd16, 2'b00, 8'd8, 17'h00000},
          {3'd6, 1'b1, 5'h08, 7'd24, 1'b1, 8'd64, 4'd1, 4'd0, 2'b10}},
        '{28'hf400000, 17'h1e12f, {5'd15, 2'b01, 8'd0, 17'h00000},
          {3'd7, 1'b1, 5'h10, 7'd50, 1'b0, 8'd128, 4'd4, 4'd0, 2'b01}},
        '{28'h1bf07ff, 17'h015d0, {5'd1, 2'b10, 8'd0, 17'h1ffff},
          {3'd0, 1'b0, 5'h0a, 7'd100, 1'b1, 8'd64, 4'd8, 4'd0, 2'b00}}};

    acr_host_model host (.clk, .wrEn, .wrAddr, .wrData, .rdAddr, .rdData);
    acr_config_regs uut (.clk, .rstn, .wrEn, .wrAddr, .wrData, .rdAddr,
        .rdData, .convBusy, .measStart, .measDone, .opMode, .chanB,
        .seqLen, .dechopEn, .chopEn, .srcCurrentUa, .inputSwitch,
        .voltSwitch, .powerDown, .voltCalIdx, .calFixed, .pathSwitch,
        .gainValue, .osfHigh, .osrRatio, .chopRatio, .avgLog2,
        .avgReserved, .rawMode);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic chk(input string n, input logic [34:0] s, e);
        numChecks++;
        if (s !== e) begin
            badCount++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic chkMode(input acr_mode_t e);
        numChecks++;
        if (opMode !== e) begin
            badCount++;
            $display("[ERR] opMode expected %h seen %h", e, opMode);
        end
    endtask : chkMode

    task automatic done(input string n);
        $display("test %s done", n);
    endtask : done

    task automatic pulseDone();
        measDone = 1'b1;
        cyc(1);
        measDone = 1'b0;
        cyc(2);
    endtask : pulseDone

    task automatic chkDef();
        chk("genDef", 35'(genV), 35'(32'h0e00_0004));
        chk("chaDef", chaV, {3'd0, 1'b0, 5'h01, 7'd100, 1'b1, 8'd64,
            4'd4, 4'd0, 2'b00});
        chkMode(MODE_FUSE_LOAD);
        host.rd(ADDR_GEN, d);
        chk("genRd", 35'(d), 35'(28'h1c00004));
        host.rd(ADDR_CHA, d);
        chk("chaRd", 35'(d), 35'(17'h003c0));
    endtask : chkDef

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    // Whole run is about 220 cycles; eighteen times that is a hang
    initial begin
        #(40 * 4000);
        badCount++;
        end_of_test();
    end

    initial begin
        rstn = 1'b0;
        convBusy = 1'b0;
        measStart = 1'b0;
        measDone = 1'b0;
        cyc(20);
        rstn = 1'b1;
        cyc(1);
        chkDef();
        done("defaults");
        foreach (rows[i]) begin
            host.wr(ADDR_GEN, rows[i].gen);
            host.wr(ADDR_CHA, 28'(rows[i].cha));
            cyc(4);
            chk("genOut", 35'(genV), 35'(rows[i].eg));
            chk("chaOut", chaV, rows[i].ec);
            host.rd(ADDR_CHA, d);
            chk("chaRd", 35'(d), 35'(rows[i].cha));
        end
        done("rows");
        // Writes in busy time wait for the next measurement start
        convBusy = 1'b1;
        host.wr(ADDR_GEN, rows[0].gen);
        host.wr(ADDR_CHA, 28'(rows[0].cha));
        cyc(4);
        chk("genBusy", 35'(genV), 35'(rows[3].eg));
        chk("chaBusy", chaV, rows[3].ec);
        host.rd(ADDR_CHA, d);
        chk("shadowRd", 35'(d), 35'(rows[0].cha));
        measStart = 1'b1;
        cyc(1);
        measStart = 1'b0;
        cyc(3);
        chk("chaStart", chaV, rows[0].ec);
        chk("genStart", 35'(genV), 35'(rows[0].eg));
        convBusy = 1'b0;
        done("busy");
        host.wr(ADDR_GEN, 28'h2c00004);
        host.wr(ADDR_MODE, 28'h2);
        cyc(4);
        pulseDone();
        chk("chanB1", 35'(chanB), 35'(0));
        pulseDone();
        chk("chanB2", 35'(chanB), 35'(1));
        host.wr(ADDR_MODE, 28'h1);
        cyc(2);
        pulseDone();
        pulseDone();
        chk("chanBSingle", 35'(chanB), 35'(0));
        done("dual");
        for (int i = 0; i < 16; i++) begin
            host.wr(ADDR_MODE, 28'(i));
            cyc(2);
            chkMode(i > 7 ? MODE_TEST_RSVD : acr_mode_t'(i));
            host.rd(ADDR_MODE, d);
            chk("modeRd", 35'(d), 35'(i));
        end
        host.rd(4'h2, d);
        chk("unmapped2", 35'(d), 35'(0));
        host.rd(4'hf, d);
        chk("unmappedF", 35'(d), 35'(0));
        done("modes");
        host.wr(ADDR_MODE, 28'h2);
        pulseDone();
        pulseDone();
        chk("chanBPre", 35'(chanB), 35'(1));
        rstn = 1'b0;
        cyc(2);
        chk("chanBRst", 35'(chanB), 35'(0));
        rstn = 1'b1;
        cyc(1);
        chkDef();
        done("reset");
        end_of_test();
    end
endmodule : tb
